// [src/oftp_defines.vh]
// Constants for the output data format and test pattern register block
`ifndef OFTP_DEFINES_VH
`define OFTP_DEFINES_VH
// Serial frame
`define OFTP_FRAME_BITS 5'h10
`define OFTP_HDR_BITS 5'h08
`define OFTP_ADDR_W 7
`define OFTP_RW_BIT 15
`define OFTP_ADDR_HI 14
`define OFTP_ADDR_LO 8
`define OFTP_HDR_RW_BIT 7
`define OFTP_DATA_MSB 7
// Register addresses
`define OFTP_ADDR_RESET 7'h00
`define OFTP_ADDR_FORMAT 7'h04
// Reset register field
`define OFTP_SWRST_BIT 7
// Format register fields
`define OFTP_TEST_HI 5
`define OFTP_TEST_LO 3
`define OFTP_ALT_POL_BIT 2
`define OFTP_SCRAMBLE_BIT 1
`define OFTP_FMT_BIT 0
`define OFTP_FMT_W 6
`define OFTP_FMT_RST 6'h00
// Test select codes
`define OFTP_TEST_OFF 3'h0
`define OFTP_TEST_ZERO 3'h1
`define OFTP_TEST_ONE 3'h3
`define OFTP_TEST_CHECK 3'h5
`define OFTP_TEST_ALT 3'h7
// Output word: overrange flag plus sample bits
`define OFTP_SAMPLE_W 14
`define OFTP_WORD_W 15
`define OFTP_PAT_ZERO 15'h0000
`define OFTP_PAT_ONE 15'h7FFF
`define OFTP_PAT_CHECK_A 15'h5555
`define OFTP_PAT_CHECK_B 15'h2AAA
`define OFTP_ALT_POL_MASK 14'h2AAA
`define OFTP_MSB_MASK 14'h2000
`endif

// [src/oftp_buf2.v]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module oftp_buf2 #(
  parameter WIDTH = 15
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // Drain side
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg rd_ptr_q;
  reg wr_ptr_q;
  reg [1:0] count_q;
  reg in_ready_q;
  reg out_valid_q;
  reg [WIDTH-1:0] out_data_q;
  wire push;
  wire pop;
  reg [1:0] count_d;
  reg rd_ptr_d;

  assign push = in_valid & in_ready_q;
  assign pop = out_valid_q & out_ready;
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  always @* begin
    count_d = count_q;
    rd_ptr_d = rd_ptr_q;
    if (push & ~pop) begin
      count_d = count_q + 2'h1;
    end else if (pop & ~push) begin
      count_d = count_q - 2'h1;
    end
    if (pop) begin
      rd_ptr_d = ~rd_ptr_q;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q <= 2'h0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data;
        wr_ptr_q <= ~wr_ptr_q;
      end
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      in_ready_q <= (count_d != 2'h2);
      out_valid_q <= (count_d != 2'h0);
      // Head entry, bypassing the memory when it is written this cycle
      if (count_d == 2'h0) begin
        out_data_q <= {WIDTH{1'b0}};
      end else if (push && (count_q == 2'h0 || (count_q == 2'h1 && pop))) begin
        out_data_q <= in_data;
      end else begin
        out_data_q <= mem_q[rd_ptr_d];
      end
    end
  end
endmodule

// [src/oftp_top.v]
// Output data format register, serial config port and output word formatter
//
// Operation
// - Test select zero passes normal conversion results to the output word.
// - Test select one drives all sample bits and the overrange flag low.
// - Test select three drives all sample bits and the overrange flag high.
// - Test select five alternates two complementary checkerboard words on successive samples.
// - Test select seven alternates all-low and all-high words on successive samples.
// - Bit 2 enables the alternate bit polarity output mode.
// - Bit 1 enables the data output randomizer.
// - The upper two register bits are ignored on write and read as zero.
// - A 16-bit frame of flag, seven address bits and eight data bits writes, or with flag high reads back.
// - A software reset command clears the whole register to zero.
`timescale 1ns/1ps
`include "oftp_defines.vh"
module oftp_top (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Serial configuration port
  input wire cs_n,
  input wire sck,
  input wire sdi,
  output wire sdo_o,
  output wire sdo_oe,
  // Conversion results in
  input wire sample_valid,
  input wire [13:0] sample_bits_in,
  input wire overrange_in,
  output wire sample_ready,
  // Formatted output word
  output wire out_valid,
  output wire [13:0] sample_bits_out,
  output wire overrange_flag_out,
  input wire out_ready,
  // Register state
  output wire [5:0] format_reg_out
);
  // Pin synchronisers
  reg cs_n_m_q;
  reg cs_n_s_q;
  reg cs_n_p_q;
  reg sck_m_q;
  reg sck_s_q;
  reg sck_p_q;
  reg sdi_m_q;
  reg sdi_s_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      cs_n_m_q <= 1'b1;
      cs_n_s_q <= 1'b1;
      cs_n_p_q <= 1'b1;
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sck_p_q <= 1'b0;
      sdi_m_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end else begin
      cs_n_m_q <= cs_n;
      cs_n_s_q <= cs_n_m_q;
      cs_n_p_q <= cs_n_s_q;
      sck_m_q <= sck;
      sck_s_q <= sck_m_q;
      sck_p_q <= sck_s_q;
      sdi_m_q <= sdi;
      sdi_s_q <= sdi_m_q;
    end
  end

  wire sck_rise;
  wire sck_fall;
  wire frame_start;
  wire frame_end;
  assign sck_rise = sck_s_q & ~sck_p_q & ~cs_n_s_q;
  assign sck_fall = ~sck_s_q & sck_p_q & ~cs_n_s_q;
  assign frame_start = ~cs_n_s_q & cs_n_p_q;
  assign frame_end = cs_n_s_q & ~cs_n_p_q;

  // Serial frame state
  reg [4:0] bit_cnt_q;
  reg [15:0] shift_q;
  reg rd_act_q;
  reg rd_act_d;
  reg [7:0] rd_shift_q;
  reg [7:0] rd_shift_d;
  reg sdo_oe_q;
  reg [`OFTP_FMT_W-1:0] fmt_q;
  reg [`OFTP_FMT_W-1:0] fmt_d;
  wire [15:0] shift_nx;
  wire [`OFTP_ADDR_W-1:0] hdr_addr;
  wire hdr_read;
  wire [7:0] rd_value;

  assign shift_nx = {shift_q[14:0], sdi_s_q};
  // Header is complete on the eighth rising edge
  assign hdr_read = shift_nx[`OFTP_HDR_RW_BIT];
  assign hdr_addr = shift_nx[`OFTP_ADDR_W-1:0];
  // Reserved bits 7 and 6 read as zero
  assign rd_value = (hdr_addr == `OFTP_ADDR_FORMAT) ? {2'h0, fmt_q} : 8'h00;

  always @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end else if (frame_start) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end else if (sck_rise && bit_cnt_q != `OFTP_FRAME_BITS) begin
      // Edges after the sixteenth are ignored
      bit_cnt_q <= bit_cnt_q + 5'h01;
      shift_q <= shift_nx;
    end
  end

  // Frame progress: header bits, data bits, full frame
  localparam [3:0] FR_IDLE = 4'h1;
  localparam [3:0] FR_HEAD = 4'h2;
  localparam [3:0] FR_DATA = 4'h4;
  localparam [3:0] FR_FULL = 4'h8;
  reg [3:0] frame_q;
  reg [3:0] frame_d;

  always @* begin
    frame_d = frame_q;
    case (frame_q)
      FR_IDLE: begin
        if (frame_start) begin
          frame_d = FR_HEAD;
        end
      end
      FR_HEAD: begin
        if (frame_end) begin
          frame_d = FR_IDLE;
        end else if (sck_rise && bit_cnt_q == `OFTP_HDR_BITS - 5'h01) begin
          frame_d = FR_DATA;
        end
      end
      FR_DATA: begin
        if (frame_end) begin
          frame_d = FR_IDLE;
        end else if (sck_rise && bit_cnt_q == `OFTP_FRAME_BITS - 5'h01) begin
          frame_d = FR_FULL;
        end
      end
      FR_FULL: begin
        if (frame_end) begin
          frame_d = FR_IDLE;
        end
      end
      default: begin
        frame_d = FR_IDLE;
      end
    endcase
    // A new select edge always restarts the frame
    if (frame_start) begin
      frame_d = FR_HEAD;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      frame_q <= FR_IDLE;
    end else begin
      frame_q <= frame_d;
    end
  end

  // Read back path, open drain pulling low only
  always @* begin
    rd_act_d = rd_act_q;
    rd_shift_d = rd_shift_q;
    if (frame_start || frame_end) begin
      rd_act_d = 1'b0;
      rd_shift_d = 8'h00;
    end else if (sck_rise && bit_cnt_q == `OFTP_HDR_BITS - 5'h01) begin
      rd_act_d = hdr_read;
      rd_shift_d = rd_value;
    end else if (sck_fall && rd_act_q && bit_cnt_q != `OFTP_HDR_BITS) begin
      rd_shift_d = {rd_shift_q[`OFTP_DATA_MSB-1:0], 1'b0};
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      rd_act_q <= 1'b0;
      rd_shift_q <= 8'h00;
      sdo_oe_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act_d;
      rd_shift_q <= rd_shift_d;
      sdo_oe_q <= rd_act_d & ~rd_shift_d[`OFTP_DATA_MSB];
    end
  end

  assign sdo_o = 1'b0;
  assign sdo_oe = sdo_oe_q;

  // Register update at the close of a full write frame
  wire wr_frame;
  assign wr_frame = frame_end && frame_q == FR_FULL && !shift_q[`OFTP_RW_BIT];

  always @* begin
    fmt_d = fmt_q;
    if (wr_frame) begin
      if (shift_q[`OFTP_ADDR_HI:`OFTP_ADDR_LO] == `OFTP_ADDR_RESET && shift_q[`OFTP_SWRST_BIT]) begin
        fmt_d = `OFTP_FMT_RST;
      end else if (shift_q[`OFTP_ADDR_HI:`OFTP_ADDR_LO] == `OFTP_ADDR_FORMAT) begin
        fmt_d = shift_q[`OFTP_FMT_W-1:0];
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      fmt_q <= `OFTP_FMT_RST;
    end else begin
      fmt_q <= fmt_d;
    end
  end

  reg [`OFTP_FMT_W-1:0] fmt_out_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      fmt_out_q <= `OFTP_FMT_RST;
    end else begin
      fmt_out_q <= fmt_d;
    end
  end
  assign format_reg_out = fmt_out_q;

  // Output word formatter
  wire [2:0] output_test_select;
  wire alt_polarity_enable;
  wire output_scramble_enable;
  wire number_format_select;
  assign output_test_select = fmt_q[`OFTP_TEST_HI:`OFTP_TEST_LO];
  assign alt_polarity_enable = fmt_q[`OFTP_ALT_POL_BIT];
  assign output_scramble_enable = fmt_q[`OFTP_SCRAMBLE_BIT];
  assign number_format_select = fmt_q[`OFTP_FMT_BIT];

  reg phase_q;
  wire buf_in_ready;
  wire take;
  assign take = sample_valid & buf_in_ready;

  // Phase steps once per accepted sample
  always @(posedge clk) begin
    if (sys_rst) begin
      phase_q <= 1'b0;
    end else if (take) begin
      phase_q <= ~phase_q;
    end
  end

  reg [13:0] norm_bits;
  reg [`OFTP_WORD_W-1:0] word_d;
  wire [`OFTP_SAMPLE_W-1:0] fmt_bits;
  wire [`OFTP_SAMPLE_W-1:0] scr_bits;
  genvar g;

  // Number format: flip the sign bit
  assign fmt_bits = number_format_select ? (sample_bits_in ^ `OFTP_MSB_MASK) : sample_bits_in;
  assign scr_bits[0] = fmt_bits[0];
  generate
    for (g = 1; g < `OFTP_SAMPLE_W; g = g + 1) begin : g_scr
      assign scr_bits[g] = fmt_bits[g] ^ (output_scramble_enable & fmt_bits[0]);
    end
  endgenerate

  always @* begin
    norm_bits = scr_bits;
    if (alt_polarity_enable) begin
      norm_bits = norm_bits ^ `OFTP_ALT_POL_MASK;
    end
    case (output_test_select)
      `OFTP_TEST_OFF: word_d = {overrange_in, norm_bits};
      `OFTP_TEST_ZERO: word_d = `OFTP_PAT_ZERO;
      `OFTP_TEST_ONE: word_d = `OFTP_PAT_ONE;
      `OFTP_TEST_CHECK: word_d = phase_q ? `OFTP_PAT_CHECK_B : `OFTP_PAT_CHECK_A;
      `OFTP_TEST_ALT: word_d = phase_q ? `OFTP_PAT_ONE : `OFTP_PAT_ZERO;
      default: word_d = {overrange_in, norm_bits};
    endcase
  end

  // Buffer toward capture logic
  wire [`OFTP_WORD_W-1:0] buf_out;
  oftp_buf2 #(
    .WIDTH(`OFTP_WORD_W)
  ) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(sample_valid),
    .in_data(word_d),
    .in_ready(buf_in_ready),
    .out_valid(out_valid),
    .out_data(buf_out),
    .out_ready(out_ready)
  );

  assign sample_ready = buf_in_ready;
  assign overrange_flag_out = buf_out[`OFTP_WORD_W-1];
  assign sample_bits_out = buf_out[`OFTP_SAMPLE_W-1:0];
endmodule

// [sim/oftp_chk.sv]
// Port assertions for the format register block
`timescale 1ns/1ps
module oftp_chk (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Serial port
  input wire cs_n,
  input wire sdo_oe,
  // Data path
  input wire sample_valid,
  input wire [13:0] sample_bits_in,
  input wire overrange_in,
  input wire sample_ready,
  input wire out_valid,
  input wire [13:0] sample_bits_out,
  input wire overrange_flag_out,
  input wire out_ready,
  input wire [5:0] format_reg_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire take = sample_valid && sample_ready && !out_valid;
  wire [2:0] ts = format_reg_out[5:3];
  wire [14:0] w = {overrange_flag_out, sample_bits_out};
  wire [14:0] wi = {overrange_in, sample_bits_in};
  a_rst_clear: assert property (disable iff (1'b0)
    sys_rst |=> !out_valid && !sdo_oe && format_reg_out == 6'h00) else $error("reset state wrong");
  a_plain_pass: assert property (take && format_reg_out == 6'h00 |=> out_valid && w == $past(wi))
    else $error("plain word altered");
  a_zero_word: assert property (take && ts == 3'h1 |=> out_valid && w == 15'h0000)
    else $error("zero pattern wrong");
  a_ones_word: assert property (take && ts == 3'h3 |=> out_valid && w == 15'h7FFF)
    else $error("ones pattern wrong");
  a_check_word: assert property (take && ts == 3'h5 |=> w == 15'h5555 || w == 15'h2AAA)
    else $error("checkerboard word wrong");
  a_alt_pol_flip: assert property (take && format_reg_out == 6'h04 |=> w == ($past(wi) ^ 15'h2AAA))
    else $error("odd bits not inverted");
  a_word_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(w))
    else $error("word dropped in stall");
  a_reg_quiet: assert property (!$stable(format_reg_out) |-> cs_n && $past(cs_n))
    else $error("register changed in frame");
endmodule

// [sim/oftp_cap.sv]
// Capture logic model that stalls on request
`timescale 1ns/1ps
module oftp_cap (
  // Clock and stall request
  input wire clk,
  input wire stall,
  // Accept strobe
  output reg out_ready
);
  reg [31:0] r;
  initial out_ready = 1'b0;
  always @(negedge clk) begin
    r = $urandom;
    out_ready <= !stall || r[1:0] == 2'b00;
  end
endmodule

// [sim/test_oftp_top.sv]
// Bench for the format register block
`timescale 1ns/1ps
module test_oftp_top;
  reg clk = 0, sys_rst = 1, cs_n = 1, sck = 0, sdi = 0, stall = 0, run = 0;
  reg sample_valid = 0, overrange_in = 0;
  reg [13:0] sample_bits_in = 14'h0000;
  wire sdo_o, sdo_oe, sample_ready, out_valid, overrange_flag_out, out_ready;
  wire [13:0] sample_bits_out;
  wire [5:0] format_reg_out;
  wire sdo_line = sdo_oe ? sdo_o : 1'b1;
  integer miscompares = 0, checks = 0, i, j;
  reg [21:0] q[$];
  reg [21:0] e;
  reg [14:0] w;
  reg ph = 0;
  reg [7:0] rd, v;
  reg [31:0] r;
  reg [2:0] c;
  always #50 clk = ~clk;
  oftp_top i_oftp_top (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .sample_valid(sample_valid), .sample_bits_in(sample_bits_in),
    .overrange_in(overrange_in), .sample_ready(sample_ready), .out_valid(out_valid),
    .sample_bits_out(sample_bits_out), .overrange_flag_out(overrange_flag_out),
    .out_ready(out_ready), .format_reg_out(format_reg_out));
  oftp_cap i_oftp_cap (.clk(clk), .stall(stall), .out_ready(out_ready));
  task chk(input string nm, input [14:0] x, input [14:0] g);
    begin
      checks = checks + 1;
      if (g !== x) begin
        miscompares = miscompares + 1;
        $display("mismatch %s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task xfer(input [15:0] f);
    integer k;
    begin
      cs_n = 0;
      for (k = 15; k >= 0; k = k - 1) begin
        sdi = f[k];
        cyc(6);
        sck = 1;
        cyc(5);
        if (k <= 7) rd[k] = sdo_line;
        cyc(1);
        sck = 0;
      end
      cyc(6);
      cs_n = 1;
      cyc(8);
    end
  endtask
  // Entry: phase, format bits, overrange, sample bits
  function [14:0] ex(input [21:0] d);
    reg [13:0] s;
    begin
      s = d[13:0];
      if (d[15]) s[13] = ~s[13];
      if (d[16]) s[13:1] = s[13:1] ^ {13{s[0]}};
      if (d[17]) s = s ^ 14'h2AAA;
      case (d[20:18])
        3'h1: ex = 15'h0000;
        3'h3: ex = 15'h7FFF;
        3'h5: ex = d[21] ? 15'h2AAA : 15'h5555;
        3'h7: ex = d[21] ? 15'h7FFF : 15'h0000;
        default: ex = {d[14], s};
      endcase
    end
  endfunction
  always @(negedge clk) begin
    r = $urandom;
    sample_valid <= run && r[1:0] != 2'b00;
    sample_bits_in <= r[29:16];
    overrange_in <= r[8];
  end
  always @(posedge clk) if (!sys_rst) begin
    if (sample_valid && sample_ready) begin
      q.push_back({ph, format_reg_out, overrange_in, sample_bits_in});
      ph = ~ph;
    end
    if (out_valid && out_ready) begin
      e = q.pop_front();
      w = {overrange_flag_out, sample_bits_out};
      chk("word", ex(e), w);
    end
  end else begin
    ph = 0;
  end
  initial begin
    r = $urandom(32'h0263);
    cyc(2);
    sys_rst = 0;
    cyc(3);
    chk("reg", 15'h0000, {9'h000, format_reg_out});
    for (i = 0; i < 10; i = i + 1) begin
      c = (i % 5 == 0) ? 3'h0 : 2 * (i % 5) - 1;
      r = $urandom;
      v = {r[7:6], c, (i == 0) ? 3'h0 : (i == 5) ? 3'h4 : r[2:0]};
      xfer({1'b0, 7'h04, v});
      chk("reg", {9'h000, v[5:0]}, {9'h000, format_reg_out});
      xfer({1'b1, 7'h04, 8'h00});
      chk("rdback", {9'h000, v[5:0]}, {7'h00, rd});
      stall = i[0];
      run = 1;
      cyc(40);
      run = 0;
      stall = 0;
      for (j = 0; j < 100 && q.size() > 0; j = j + 1) cyc(1);
      if (q.size() > 0) begin
        miscompares = miscompares + 1;
        print_verdict;
      end
    end
    xfer({1'b0, 7'h11, 8'h3F});
    chk("reg", {9'h000, v[5:0]}, {9'h000, format_reg_out});
    xfer({1'b1, 7'h11, 8'hFF});
    chk("unmapped", 15'h0000, {7'h00, rd});
    xfer({1'b0, 7'h00, 8'h80});
    chk("reg", 15'h0000, {9'h000, format_reg_out});
    xfer({1'b0, 7'h04, 8'hFF});
    sys_rst = 1;
    cyc(2);
    sys_rst = 0;
    cyc(1);
    chk("reg", 15'h0000, {9'h000, format_reg_out});
    print_verdict;
  end
endmodule
bind oftp_top oftp_chk i_oftp_chk (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sdo_oe(sdo_oe),
  .sample_valid(sample_valid), .sample_bits_in(sample_bits_in), .overrange_in(overrange_in),
  .sample_ready(sample_ready), .out_valid(out_valid), .sample_bits_out(sample_bits_out),
  .overrange_flag_out(overrange_flag_out), .out_ready(out_ready), .format_reg_out(format_reg_out));
